// >>> design/shift_unit_top.sv
// Word n-bit shifter plus two bit-table shift registers behind AHB-Lite.
// Assumes one AHB-Lite master, single word transfers, hready = hreadyout.
`timescale 1ns/1ps

`include "shift_unit_params.svh"

module shift_unit_top (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire shift_unit_pkg::bus_word_t haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire shift_unit_pkg::bus_word_t hwdata,
	input wire logic hready,
	output logic hreadyout,
	output shift_unit_pkg::bus_word_t hrdata,
	output logic hresp
);
	import shift_unit_pkg::*;

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic acc;
	logic dp_wr_r;
	logic dp_rd_r;
	reg_addr_t dp_addr_r;
	bus_word_t hrdata_r;
	bus_word_t rd_mux;
	logic wr_src;
	logic wr_wcfg;
	logic wr_ucfg;
	logic wr_bcfg;
	logic wr_exec;

	word_t word_src_r;
	logic [`WORD_N_W-1:0] word_n_r;
	logic word_left_r;
	logic word_in_r;
	word_t word_dst_r;
	logic word_out_r;
	logic word_exec_r;
	logic uni_exec_r;
	logic bi_exec_r;
	logic [`TBL_CFG_W-1:0] uni_cfg_r;
	logic [`TBL_CFG_W-1:0] bi_cfg_r;
	logic carry_flag_r;

	logic word_n_ok;
	logic word_go;
	logic [`WORD_W:0] word_res;
	word_t word_res_val;
	logic word_res_c;
	logic word_out_nxt;
	bus_word_t status_v;

	table_if uni_if ();
	table_if bi_if ();

	// ----------------------------------------------------------------
	// Word shift through a wide window; carry is the first bit past edge
	// ----------------------------------------------------------------
	function automatic logic [`WORD_W:0] word_shift(
		input word_t src,
		input logic [`WORD_N_W-1:0] n,
		input logic left
	);
		logic [2*`WORD_W-1:0] lw;
		logic [2*`WORD_W-1:0] rw;
		lw = {{`WORD_W{1'b0}}, src} << n;
		rw = {src, {`WORD_W{1'b0}}} >> n;
		if (left) begin
			word_shift = {lw[`WORD_W], lw[`WORD_W-1:0]};
		end else begin
			word_shift = {rw[`WORD_W-1], rw[2*`WORD_W-1:`WORD_W]};
		end
	endfunction

	// ----------------------------------------------------------------
	// AHB-Lite slave: writes have no wait, reads take one wait state
	// ----------------------------------------------------------------
	assign acc = hsel && htrans[1] && hready;
	assign hreadyout = !dp_rd_r;
	assign hrdata = hrdata_r;
	assign hresp = 1'b0;

	// Address phase capture
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_wr_r <= 1'b0;
			dp_rd_r <= 1'b0;
			dp_addr_r <= '0;
		end else begin
			dp_wr_r <= acc && hwrite;
			dp_rd_r <= acc && !hwrite;
			dp_addr_r <= acc ? haddr[`ADDR_W-1:0] : dp_addr_r;
		end
	end

	// Write strobes for the data phase
	assign wr_src = dp_wr_r && (dp_addr_r == `OFF_WORD_SRC);
	assign wr_wcfg = dp_wr_r && (dp_addr_r == `OFF_WORD_CFG);
	assign wr_ucfg = dp_wr_r && (dp_addr_r == `OFF_UNI_CFG);
	assign wr_bcfg = dp_wr_r && (dp_addr_r == `OFF_BI_CFG);
	assign wr_exec = dp_wr_r && (dp_addr_r == `OFF_EXEC);

	// Status word: outputs and the shared carry flag
	assign status_v = {28'h0000000, carry_flag_r, bi_if.out_bit, uni_if.out_bit, word_out_r};

	// Read selection; unmapped offsets read zero
	assign rd_mux =
		(dp_addr_r == `OFF_WORD_SRC) ? bus_word_t'(word_src_r) :
		(dp_addr_r == `OFF_WORD_CFG) ? bus_word_t'({word_in_r, word_left_r, 3'h0, word_n_r}) :
		(dp_addr_r == `OFF_WORD_DST) ? bus_word_t'(word_dst_r) :
		(dp_addr_r == `OFF_UNI_CFG) ? bus_word_t'(uni_cfg_r) :
		(dp_addr_r == `OFF_BI_CFG) ? bus_word_t'(bi_cfg_r) :
		(dp_addr_r == `OFF_STATUS) ? status_v :
		(dp_addr_r == `OFF_UNI_LO) ? uni_if.tbl[31:0] :
		(dp_addr_r == `OFF_UNI_HI) ? uni_if.tbl[63:32] :
		(dp_addr_r == `OFF_BI_LO) ? bi_if.tbl[31:0] :
		(dp_addr_r == `OFF_BI_HI) ? bi_if.tbl[63:32] :
		32'h00000000;

	// Read data registered during the wait state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_r <= '0;
		end else if (dp_rd_r) begin
			hrdata_r <= rd_mux;
		end
	end

	// ----------------------------------------------------------------
	// Operand registers written by software
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			word_src_r <= '0;
			word_n_r <= `WORD_N_RST;
			word_left_r <= 1'b0;
			word_in_r <= 1'b0;
			uni_cfg_r <= `TCFG_RST;
			bi_cfg_r <= `TCFG_RST;
		end else begin
			if (wr_src) begin
				word_src_r <= hwdata[`WORD_W-1:0];
			end
			if (wr_wcfg) begin
				word_n_r <= hwdata[`WORD_N_W-1:0];
				word_left_r <= hwdata[`WCFG_LEFT];
				word_in_r <= hwdata[`WCFG_INPUT];
			end
			if (wr_ucfg) begin
				uni_cfg_r <= hwdata[`TBL_CFG_W-1:0];
			end
			if (wr_bcfg) begin
				bi_cfg_r <= hwdata[`TBL_CFG_W-1:0];
			end
		end
	end

	// One-cycle execute strobes, one per written exec bit
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			word_exec_r <= 1'b0;
			uni_exec_r <= 1'b0;
			bi_exec_r <= 1'b0;
		end else begin
			word_exec_r <= wr_exec && hwdata[`EXEC_WORD];
			uni_exec_r <= wr_exec && hwdata[`EXEC_UNI];
			bi_exec_r <= wr_exec && hwdata[`EXEC_BI];
		end
	end

	// ----------------------------------------------------------------
	// Word n-bit shift datapath
	// ----------------------------------------------------------------
	assign word_n_ok = (word_n_r >= `WORD_N_MIN) && (word_n_r <= `WORD_N_MAX);
	assign word_go = word_exec_r && word_in_r && word_n_ok;
	assign word_res = word_shift(word_src_r, word_n_r, word_left_r);
	assign word_res_val = word_res[`WORD_W-1:0];
	assign word_res_c = word_res[`WORD_W];
	assign word_out_nxt = word_go && (word_left_r ? word_res_val[`WORD_W-1] : word_res_val[0]);

	// Destination and output change only on the word strobe
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			word_dst_r <= '0;
			word_out_r <= 1'b0;
		end else if (word_exec_r) begin
			if (word_go) begin
				word_dst_r <= word_res_val;
			end
			word_out_r <= word_out_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Bit-table shifters; the shift level is taken at every strobe
	// ----------------------------------------------------------------
	assign uni_if.exec = uni_exec_r;
	assign uni_if.enable = uni_cfg_r[`TCFG_EN];
	assign uni_if.shift = uni_cfg_r[`TCFG_SHIFT];
	assign uni_if.data_in = uni_cfg_r[`TCFG_DATA];
	assign uni_if.dir_up = 1'b1;
	assign uni_if.len = uni_cfg_r[`TBL_LEN_W-1:0];

	assign bi_if.exec = bi_exec_r;
	assign bi_if.enable = bi_cfg_r[`TCFG_EN];
	assign bi_if.shift = bi_cfg_r[`TCFG_SHIFT];
	assign bi_if.data_in = bi_cfg_r[`TCFG_DATA];
	assign bi_if.dir_up = bi_cfg_r[`TCFG_DIR];
	assign bi_if.len = bi_cfg_r[`TBL_LEN_W-1:0];

	bit_table_shifter u_uni (
		.hclk(hclk),
		.hresetn(hresetn),
		.tif(uni_if.shifter)
	);

	bit_table_shifter u_bi (
		.hclk(hclk),
		.hresetn(hresetn),
		.tif(bi_if.shifter)
	);

	// ----------------------------------------------------------------
	// Shared carry flag; on a tie the two-way shifter wins, then one-way
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			carry_flag_r <= 1'b0;
		end else if (bi_if.carry_we) begin
			carry_flag_r <= bi_if.carry_val;
		end else if (uni_if.carry_we) begin
			carry_flag_r <= uni_if.carry_val;
		end else if (word_go) begin
			carry_flag_r <= word_res_c;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	logic [`WORD_W-1:0] right_exp;
	logic [`WORD_W-1:0] left_exp;
	logic others_idle;
	assign right_exp = word_src_r >> word_n_r;
	assign left_exp = word_src_r << word_n_r;
	assign others_idle = !uni_exec_r && !bi_exec_r;

	sequence s_word_on;
		word_exec_r && word_in_r && word_n_ok && others_idle;
	endsequence

	property p_word_right;
		s_word_on ##0 !word_left_r |=> (word_dst_r == $past(right_exp)) &&
			(word_out_r == word_dst_r[0]);
	endproperty
	a_word_right: assert property (p_word_right) else $error("right shift result wrong");

	property p_word_left;
		s_word_on ##0 word_left_r |=> (word_dst_r == $past(left_exp)) &&
			(word_out_r == word_dst_r[`WORD_W-1]);
	endproperty
	a_word_left: assert property (p_word_left) else $error("left shift result wrong");

	property p_word_carry16;
		s_word_on ##0 (word_n_r == `WORD_N_MAX) |=>
			(word_dst_r == '0) && (carry_flag_r == ($past(word_left_r) ? $past(word_src_r[0])
			: $past(word_src_r[`WORD_W-1])));
	endproperty
	a_word_carry16: assert property (p_word_carry16) else $error("full shift carry wrong");

	property p_word_off;
		word_exec_r && !word_in_r && others_idle |=> !word_out_r && $stable(word_dst_r) &&
			$stable(carry_flag_r);
	endproperty
	a_word_off: assert property (p_word_off) else $error("word shift ran with input off");

	property p_strobe_only;
		!word_exec_r |=> $stable(word_dst_r) && $stable(word_out_r);
	endproperty
	a_strobe_only: assert property (p_strobe_only) else $error("word state moved without strobe");
endmodule

// >>> common/shift_unit_params.svh
// Constants of the word shifter and bit-table shift register unit.
// Assumes inclusion by bare name from the package and the design files.
`ifndef SHIFT_UNIT_PARAMS_SVH
`define SHIFT_UNIT_PARAMS_SVH

// ----------------------------------------------------------------
// Widths and ranges
// ----------------------------------------------------------------
`define WORD_W 16
`define WORD_N_W 5
`define WORD_N_MIN 5'h01
`define WORD_N_MAX 5'h10
`define TBL_MAX 64
`define TBL_LEN_W 7
`define TBL_LEN_MAX 7'h40
`define TBL_CFG_W 12
`define ADDR_W 8

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFF_WORD_SRC 8'h00
`define OFF_WORD_CFG 8'h04
`define OFF_WORD_DST 8'h08
`define OFF_UNI_CFG 8'h0C
`define OFF_BI_CFG 8'h10
`define OFF_EXEC 8'h14
`define OFF_STATUS 8'h18
`define OFF_UNI_LO 8'h1C
`define OFF_UNI_HI 8'h20
`define OFF_BI_LO 8'h24
`define OFF_BI_HI 8'h28

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define WCFG_LEFT 8
`define WCFG_INPUT 9
`define TCFG_DATA 8
`define TCFG_SHIFT 9
`define TCFG_EN 10
`define TCFG_DIR 11
`define EXEC_WORD 0
`define EXEC_UNI 1
`define EXEC_BI 2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define WORD_N_RST 5'h01
`define TCFG_RST 12'h040

`endif

// >>> common/shift_unit_pkg.sv
// Types shared by the shift unit, its interface and its modules.
// Assumes the constants header sits on the include path.
`include "shift_unit_params.svh"

package shift_unit_pkg;
	typedef logic [31:0] bus_word_t;
	typedef logic [`WORD_W-1:0] word_t;
	typedef logic [`TBL_MAX-1:0] table_t;
	typedef logic [`TBL_LEN_W-1:0] tbl_len_t;
	typedef logic [`ADDR_W-1:0] reg_addr_t;
endpackage

// >>> common/table_if.sv
// Connection between the unit's controller and one bit-table shifter.
// Assumes the shift unit package is compiled first.
`timescale 1ns/1ps

interface table_if;
	import shift_unit_pkg::*;
	logic exec;
	logic enable;
	logic shift;
	logic data_in;
	logic dir_up;
	tbl_len_t len;
	table_t tbl;
	logic carry_we;
	logic carry_val;
	logic out_bit;

	// Controller side drives the inputs of one execution
	modport ctl (
		output exec, enable, shift, data_in, dir_up, len,
		input tbl, carry_we, carry_val, out_bit
	);

	// Shifter side holds the table and reports carry and output
	modport shifter (
		input exec, enable, shift, data_in, dir_up, len,
		output tbl, carry_we, carry_val, out_bit
	);
endinterface

// >>> design/bit_table_shifter.sv
// Bit table of up to 64 cells, shifted one place per enabled execute strobe with shift set.
// Assumes one-cycle exec pulses from the controller on the same clock.
`timescale 1ns/1ps

module bit_table_shifter (
	input wire logic hclk,
	input wire logic hresetn,
	table_if.shifter tif
);
	import shift_unit_pkg::*;

	logic len_ok;
	logic [5:0] top_idx;
	table_t mask;
	table_t tbl_r;
	table_t tbl_nxt;
	table_t shl_v;
	table_t shr_v;
	logic do_shift;
	logic out_r;
	logic out_nxt;

	// ----------------------------------------------------------------
	// Table length and shift candidates
	// ----------------------------------------------------------------
	// An illegal length falls back to the full table
	assign len_ok = (tif.len != '0) && (tif.len <= `TBL_LEN_MAX);
	assign top_idx = len_ok ? 6'(tif.len - 7'h01) : 6'h3F;
	assign mask = table_t'({`TBL_MAX{1'b1}}) >> (6'h3F - top_idx);
	assign do_shift = tif.exec && tif.enable && tif.shift;
	assign shl_v = ((tbl_r << 1) | table_t'(tif.data_in)) & mask;
	assign shr_v = ((tbl_r >> 1) | (table_t'(tif.data_in) << top_idx)) & mask;
	assign tbl_nxt = !tif.enable ? '0 : (tif.dir_up ? shl_v : shr_v);

	// Carry is written on a shift or a clear, never on a plain hold
	assign tif.carry_we = tif.exec && (!tif.enable || tif.shift);
	assign tif.carry_val = tif.enable && (tif.dir_up ? tbl_r[top_idx] : tbl_r[0]);

	// Output: lowest cell after a right shift, else the highest cell
	assign out_nxt = !tif.enable ? 1'b0 :
		(do_shift && !tif.dir_up) ? tbl_nxt[0] :
		do_shift ? tbl_nxt[top_idx] : tbl_r[top_idx];

	// ----------------------------------------------------------------
	// Table and output state
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tbl_r <= '0;
			out_r <= 1'b0;
		end else if (tif.exec) begin
			if (!tif.enable || tif.shift) begin
				tbl_r <= tbl_nxt;
			end
			out_r <= out_nxt;
		end
	end

	assign tif.tbl = tbl_r;
	assign tif.out_bit = out_r;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_right_shift;
		tif.exec && tif.enable && tif.shift && !tif.dir_up && len_ok;
	endsequence

	property p_clear;
		tif.exec && !tif.enable |=> (tbl_r == '0) && !out_r && !tif.out_bit;
	endproperty
	a_clear: assert property (p_clear) else $error("table not cleared");

	property p_insert_up;
		tif.exec && tif.enable && tif.shift && tif.dir_up && (tif.len == 7'h01)
			|=> (tbl_r[0] == $past(tif.data_in)) && (out_r == tbl_r[0]);
	endproperty
	a_insert_up: assert property (p_insert_up) else $error("left insert wrong");

	property p_hold;
		tif.exec && tif.enable && !tif.shift |=> (tbl_r == $past(tbl_r)) && (out_r == tbl_r[top_idx]);
	endproperty
	a_hold: assert property (p_hold) else $error("table moved without shift");

	property p_right;
		s_right_shift |=> (out_r == tbl_r[0]) && (tbl_r[top_idx] == $past(tif.data_in));
	endproperty
	a_right: assert property (p_right) else $error("right shift wrong");
endmodule

// >>> bench/shift_sequencer.sv
// Sequencer model: AHB-Lite master issuing single word transfers to the unit.
// Assumes one slave whose hreadyout is the bus hready, all on hclk.
`timescale 1ns/1ps

module shift_sequencer (
	input wire logic hclk,
	input wire logic hreadyout,
	input wire shift_unit_pkg::bus_word_t hrdata,
	output logic hsel,
	output shift_unit_pkg::bus_word_t haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output shift_unit_pkg::bus_word_t hwdata
);
	import shift_unit_pkg::*;

	// Idle bus at time zero
	initial begin
		hsel = 1'b1;
		haddr = '0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = '0;
	end

	// Address phase held until hready seen high at an edge
	task automatic addr_phase(input bus_word_t a, input logic w);
		@(posedge hclk);
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
	endtask

	// One write; an exec word yields one strobe per set bit among bits 0 to 2
	task automatic write_reg(input bus_word_t a, input bus_word_t d);
		addr_phase(a, 1'b1);
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hwdata <= ~d;
	endtask

	// One read; data taken at the edge that sees hready high
	task automatic read_reg(input bus_word_t a, output bus_word_t d);
		addr_phase(a, 1'b0);
		do @(posedge hclk); while (hreadyout !== 1'b1);
		d = hrdata;
	endtask
endmodule

// >>> bench/bit_shift_and_shift_register_unit_test.sv
// Self-checking bench: behavioural model of word and table shifts vs the unit.
// Assumes the sequencer model and the unit's package and constants.
`timescale 1ns/1ps

`include "shift_unit_params.svh"

module bit_shift_and_shift_register_unit_test;
	import shift_unit_pkg::*;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [1:0] htrans;
	logic [2:0] hsize;
	bus_word_t haddr, hwdata, hrdata, rd;
	int errors, tests_run, cycles, n, len;
	logic [31:0] seed, r;
	logic [63:0] uni_t, bi_t;
	logic carry, w_out, u_out, b_out, on, left;
	word_t src, dst;

	shift_unit_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));
	shift_sequencer i_seq (.hclk(hclk), .hreadyout(hreadyout), .hrdata(hrdata),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata));

	// ------------------------------------------------------------
	// Clock, timeout and verdict
	// ------------------------------------------------------------
	initial begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end

	always @(posedge hclk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		if (errors == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic check(input bus_word_t seen, input bus_word_t exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic rd_chk(input bus_word_t a, input bus_word_t exp);
		i_seq.read_reg(a, rd);
		check(rd, exp);
		check({31'h0, hresp}, 32'h0);
	endtask

	function automatic bus_word_t status();
		return {28'h0, carry, b_out, u_out, w_out};
	endfunction

	// One table strobe; c = {dir, enable, shift, data}
	task automatic tbl_step(input int u, input logic [3:0] c);
		logic [63:0] t, m;
		logic o;
		t = u ? bi_t : uni_t;
		m = (len == 64) ? '1 : (64'h1 << len) - 64'h1;
		o = 1'b0;
		if (!c[2]) begin
			t = '0;
			carry = 1'b0;
		end else if (!c[1]) begin
			o = t[len-1];
		end else if (u == 0 || c[3]) begin
			carry = t[len-1];
			t = ((t << 1) | 64'(c[0])) & m;
			o = t[len-1];
		end else begin
			carry = t[0];
			t = (t >> 1) | (64'(c[0]) << (len - 1));
			o = t[0];
		end
		if (u == 1) begin
			bi_t = t;
			b_out = o;
		end else begin
			uni_t = t;
			u_out = o;
		end
		i_seq.write_reg(u ? `OFF_BI_CFG : `OFF_UNI_CFG,
			{20'h0, c[3] & (u == 1), c[2:0], 1'b0, 7'(len)});
		i_seq.write_reg(`OFF_EXEC, u ? 32'h4 : 32'h2);
		rd_chk(u ? `OFF_BI_LO : `OFF_UNI_LO, t[31:0]);
		rd_chk(u ? `OFF_BI_HI : `OFF_UNI_HI, t[63:32]);
		rd_chk(`OFF_STATUS, status());
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		hresetn = 1'b0;
		errors = 0;
		tests_run = 0;
		cycles = 0;
		seed = 32'h9BECC0F7;
		uni_t = '0;
		bi_t = '0;
		{carry, w_out, u_out, b_out} = 4'h0;
		dst = '0;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		// Reset values, then an unmapped place
		rd_chk(`OFF_WORD_CFG, 32'h1);
		rd_chk(`OFF_UNI_CFG, 32'h40);
		rd_chk(`OFF_BI_CFG, 32'h40);
		rd_chk(`OFF_STATUS, 32'h0);
		i_seq.write_reg(32'h3C, 32'hFFFF_FFFF);
		rd_chk(32'h3C, 32'h0);
		// Word shifts, both ways, n over 1..16, some with input off
		for (int i = 0; i < 32; i++) begin
			r = rnd();
			src = r[15:0];
			n = (i < 16) ? i + 1 : int'(r[19:16]) + 1;
			left = r[20];
			on = (i % 7 != 6);
			if (!on)
				w_out = 1'b0;
			else if (left) begin
				carry = src[16-n];
				dst = src << n;
				w_out = dst[15];
			end else begin
				carry = src[n-1];
				dst = src >> n;
				w_out = dst[0];
			end
			i_seq.write_reg(`OFF_WORD_SRC, {16'h0, src});
			i_seq.write_reg(`OFF_WORD_CFG, {22'h0, on, left, 3'h0, 5'(n)});
			i_seq.write_reg(`OFF_EXEC, 32'h1);
			rd_chk(`OFF_WORD_DST, {16'h0, dst});
			rd_chk(`OFF_STATUS, status());
		end
		// Counts outside 1..16 with the input on run nothing; the output drops
		for (int i = 0; i < 2; i++) begin
			r = rnd();
			w_out = 1'b0;
			i_seq.write_reg(`OFF_WORD_CFG, {22'h0, 1'b1, r[20], 3'h0,
				(i == 0) ? 5'h00 : (r[4:0] | 5'h11)});
			i_seq.write_reg(`OFF_EXEC, 32'h1);
			rd_chk(`OFF_WORD_DST, {16'h0, dst});
			rd_chk(`OFF_STATUS, status());
		end
		// Both tables at the shortest, longest and a random length
		for (int u = 0; u < 2; u++) begin
			for (int k = 0; k < 3; k++) begin
				r = rnd();
				len = (k == 0) ? 1 : (k == 1) ? 64 : int'(r[5:0] % 62) + 2;
				tbl_step(u, 4'h0);
				for (int s = 0; s < 24; s++) begin
					r = rnd();
					tbl_step(u, (s == 15) ? 4'h2 : (r[3:0] | 4'h4));
				end
			end
		end
		// All three strobes at once; the clearing two-way table owns the carry
		r = rnd();
		src = r[15:0];
		i_seq.write_reg(`OFF_WORD_SRC, {16'h0, src});
		i_seq.write_reg(`OFF_WORD_CFG, 32'h0000_0204);
		i_seq.write_reg(`OFF_UNI_CFG, 32'h0);
		i_seq.write_reg(`OFF_BI_CFG, 32'h0);
		i_seq.write_reg(`OFF_EXEC, 32'h7);
		dst = src >> 4;
		{carry, b_out, u_out, w_out} = {3'h0, dst[0]};
		rd_chk(`OFF_WORD_DST, {16'h0, dst});
		rd_chk(`OFF_STATUS, status());
		report_and_stop();
	end
endmodule
